// ### verilog/exec_pkg.sv
// shared constants and carrier types for the sleep/subtract/swap execution block
package exec_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] REG_INSTR_OFS = 8'h00;
  localparam logic [7:0] REG_ACC_OFS = 8'h04;
  localparam logic [7:0] REG_FILE_OFS = 8'h08;
  localparam logic [7:0] REG_RESULT_OFS = 8'h0c;
  localparam logic [7:0] REG_STATUS_OFS = 8'h10;
  localparam logic [7:0] REG_STATE_OFS = 8'h14;

  // instruction encodings
  localparam logic [11:0] OPC_SLEEP = 12'h003;
  localparam logic [5:0] OPC6_SUB = 6'h02;
  localparam logic [5:0] OPC6_SWAP = 6'h0e;

  // status register field positions
  localparam int ST_C_BIT = 0;
  localparam int ST_NB_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_PWD_BIT = 3;
  localparam int ST_TMO_BIT = 4;

  // result register field positions
  localparam int RES_ADDR_LSB = 8;
  localparam int RES_DEST_BIT = 13;

  // state register field positions
  localparam int STATE_HALT_BIT = 0;

  // values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [11:0] INSTR_RST = 12'h000;
  localparam logic TMO_RST = 1'b1;
  localparam logic PWD_RST = 1'b1;

  // destination bit values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef struct packed {
    logic [5:0] opc;
    logic dest;
    logic [4:0] faddr;
  } instr_t;

  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic nib_borrow;
    logic zero;
  } alu_out_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;

endpackage

// ### verilog/pin_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (ce_i)
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

// ### verilog/exec_alu.sv
// byte datapath: file minus accumulator, or nibble exchange of the file byte
`timescale 1ns/1ps
module exec_alu
  import exec_pkg::*;
(
  input wire logic [7:0] file_val_i,
  input wire logic [7:0] acc_val_i,
  input wire logic swap_i,
  output alu_out_t res_o
);

  logic [8:0] full_sum;
  logic [4:0] nib_sum;

  always_comb
  begin
    // two's complement: f + ~w + 1, carry out means no borrow
    full_sum = {1'b0, file_val_i} + {1'b0, ~acc_val_i} + 9'h001;
    nib_sum = {1'b0, file_val_i[3:0]} + {1'b0, ~acc_val_i[3:0]} + 5'h01;
    res_o.carry = full_sum[8];
    res_o.nib_borrow = nib_sum[4];
    if (swap_i)
    begin
      res_o.value = {file_val_i[3:0], file_val_i[7:4]};
    end
    else
    begin
      res_o.value = full_sum[7:0];
    end
    res_o.zero = (res_o.value == 8'h00);
  end

endmodule

// ### verilog/sleep_subtract_swap_exec.sv
// execution unit for low-power entry, subtract and nibble swap, with Avalon-MM registers
//
// Summary of operation
// - subtract computes file minus accumulator by two's complement, updates carry, borrow, zero.
// - subtract destination bit 0 writes accumulator, 1 writes the file register.
// - nibble swap exchanges file nibbles and leaves every status flag alone.
// - swap destination 0 goes to accumulator, 1 to file register, one cycle.
`timescale 1ns/1ps
module sleep_subtract_swap_exec
  import exec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic wake_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic file_we_o,
  output logic [4:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic lapse_clear_o,
  output logic lapse_prescale_clear_o,
  output logic osc_halt_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o
);

  // bus handshake state
  bus_state_t state_q;
  bus_state_t state_d;
  logic wait_q;
  logic wait_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // core state
  logic [11:0] instr_q;
  logic [11:0] instr_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [7:0] file_q;
  logic [7:0] file_d;
  logic [7:0] result_q;
  logic [7:0] result_d;
  logic [4:0] res_addr_q;
  logic [4:0] res_addr_d;
  logic res_dest_q;
  logic res_dest_d;
  logic carry_q;
  logic carry_d;
  logic nib_borrow_bit_q;
  logic nib_borrow_bit_d;
  logic zero_q;
  logic zero_d;
  logic timeout_flag_q;
  logic timeout_flag_d;
  logic powerdown_flag_q;
  logic powerdown_flag_d;
  logic halt_q;
  logic halt_d;
  logic file_we_q;
  logic file_we_d;
  logic [4:0] file_addr_q;
  logic [4:0] file_addr_d;
  logic [7:0] file_wdata_q;
  logic [7:0] file_wdata_d;
  logic lclr_q;
  logic lclr_d;
  logic pclr_q;
  logic pclr_d;

  logic wake_s;
  logic req;
  logic done;
  logic wr_done;
  logic fire;
  logic [11:0] instr_new;
  instr_t dec;
  logic is_sleep;
  logic is_sub;
  logic is_swap;
  alu_out_t alu;

  pin_sync #(
    .WIDTH(1)
  ) u_wake_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .async_i(wake_i),
    .sync_o(wake_s)
  );

  // decode the word being issued, not the stored one, so it executes in that same cycle
  always_comb
  begin
    instr_new = instr_q;
    if (avs_byteenable_i[0])
    begin
      instr_new[7:0] = avs_writedata_i[7:0];
    end
    if (avs_byteenable_i[1])
    begin
      instr_new[11:8] = avs_writedata_i[11:8];
    end
  end

  assign dec = instr_t'(instr_new);
  assign is_sleep = (instr_new == OPC_SLEEP);
  assign is_sub = (dec.opc == OPC6_SUB);
  assign is_swap = (dec.opc == OPC6_SWAP);

  exec_alu u_alu (
    .file_val_i(file_q),
    .acc_val_i(acc_q),
    .swap_i(is_swap),
    .res_o(alu)
  );

  assign req = avs_read_i | avs_write_i;
  assign done = ce_i && (state_q == BUS_ACK) && req;
  assign wr_done = done && avs_write_i;
  // a halted core has no oscillator, so issued words are dropped until wake
  assign fire = wr_done && (avs_address_i == REG_INSTR_OFS) && !halt_q
    && (avs_byteenable_i[1:0] != 2'b00);

  // bus handshake: one wait cycle, read data captured on the first edge
  always_comb
  begin
    state_d = state_q;
    rdata_d = rdata_q;
    case (state_q)
      BUS_IDLE:
      begin
        if (req)
        begin
          state_d = BUS_ACK;
          rdata_d = '0;
          case (avs_address_i)
            REG_INSTR_OFS: rdata_d[11:0] = instr_q;
            REG_ACC_OFS: rdata_d[7:0] = acc_q;
            REG_FILE_OFS: rdata_d[7:0] = file_q;
            REG_RESULT_OFS:
            begin
              rdata_d[7:0] = result_q;
              rdata_d[RES_ADDR_LSB +: 5] = res_addr_q;
              rdata_d[RES_DEST_BIT] = res_dest_q;
            end
            REG_STATUS_OFS:
            begin
              rdata_d[ST_C_BIT] = carry_q;
              rdata_d[ST_NB_BIT] = nib_borrow_bit_q;
              rdata_d[ST_Z_BIT] = zero_q;
              rdata_d[ST_PWD_BIT] = powerdown_flag_q;
              rdata_d[ST_TMO_BIT] = timeout_flag_q;
            end
            REG_STATE_OFS: rdata_d[STATE_HALT_BIT] = halt_q;
            default: rdata_d = '0;
          endcase
        end
      end
      BUS_ACK:
      begin
        state_d = BUS_IDLE;
      end
      default:
      begin
        state_d = BUS_IDLE;
      end
    endcase
    wait_d = (state_d != BUS_ACK);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // core: software writes first, then the instruction's own effect
  always_comb
  begin
    instr_d = instr_q;
    acc_d = acc_q;
    file_d = file_q;
    result_d = result_q;
    res_addr_d = res_addr_q;
    res_dest_d = res_dest_q;
    carry_d = carry_q;
    nib_borrow_bit_d = nib_borrow_bit_q;
    zero_d = zero_q;
    timeout_flag_d = timeout_flag_q;
    powerdown_flag_d = powerdown_flag_q;
    halt_d = halt_q;
    file_we_d = 1'b0;
    file_addr_d = file_addr_q;
    file_wdata_d = file_wdata_q;
    lclr_d = 1'b0;
    pclr_d = 1'b0;
    if (halt_q && wake_s)
    begin
      halt_d = 1'b0;
    end
    if (wr_done && avs_byteenable_i[0])
    begin
      if (avs_address_i == REG_ACC_OFS)
      begin
        acc_d = avs_writedata_i[7:0];
      end
      if (avs_address_i == REG_FILE_OFS)
      begin
        file_d = avs_writedata_i[7:0];
      end
      if (avs_address_i == REG_STATUS_OFS)
      begin
        carry_d = avs_writedata_i[ST_C_BIT];
        nib_borrow_bit_d = avs_writedata_i[ST_NB_BIT];
        zero_d = avs_writedata_i[ST_Z_BIT];
      end
    end
    if (fire)
    begin
      instr_d = instr_new;
      if (is_sleep)
      begin
        acc_d = ACC_RST;
        lclr_d = 1'b1;
        pclr_d = 1'b1;
        timeout_flag_d = 1'b1;
        powerdown_flag_d = 1'b0;
        halt_d = 1'b1;
      end
      else if (is_sub || is_swap)
      begin
        result_d = alu.value;
        res_addr_d = dec.faddr;
        res_dest_d = dec.dest;
        if (is_sub)
        begin
          carry_d = alu.carry;
          nib_borrow_bit_d = alu.nib_borrow;
          zero_d = alu.zero;
        end
        if (dec.dest == DEST_ACC)
        begin
          acc_d = alu.value;
        end
        else
        begin
          // keep the local copy coherent with the write-back
          file_d = alu.value;
          file_we_d = 1'b1;
          file_addr_d = dec.faddr;
          file_wdata_d = alu.value;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      instr_q <= INSTR_RST;
      acc_q <= ACC_RST;
      file_q <= FILE_RST;
      result_q <= 8'h00;
      res_addr_q <= 5'h00;
      res_dest_q <= 1'b0;
      carry_q <= 1'b0;
      nib_borrow_bit_q <= 1'b0;
      zero_q <= 1'b0;
      timeout_flag_q <= TMO_RST;
      powerdown_flag_q <= PWD_RST;
      halt_q <= 1'b0;
      file_we_q <= 1'b0;
      file_addr_q <= 5'h00;
      file_wdata_q <= 8'h00;
      lclr_q <= 1'b0;
      pclr_q <= 1'b0;
    end
    else if (ce_i)
    begin
      instr_q <= instr_d;
      acc_q <= acc_d;
      file_q <= file_d;
      result_q <= result_d;
      res_addr_q <= res_addr_d;
      res_dest_q <= res_dest_d;
      carry_q <= carry_d;
      nib_borrow_bit_q <= nib_borrow_bit_d;
      zero_q <= zero_d;
      timeout_flag_q <= timeout_flag_d;
      powerdown_flag_q <= powerdown_flag_d;
      halt_q <= halt_d;
      file_we_q <= file_we_d;
      file_addr_q <= file_addr_d;
      file_wdata_q <= file_wdata_d;
      lclr_q <= lclr_d;
      pclr_q <= pclr_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign file_we_o = file_we_q;
  assign file_addr_o = file_addr_q;
  assign file_wdata_o = file_wdata_q;
  assign lapse_clear_o = lclr_q;
  assign lapse_prescale_clear_o = pclr_q;
  assign osc_halt_o = halt_q;
  assign timeout_flag_o = timeout_flag_q;
  assign powerdown_flag_o = powerdown_flag_q;

  // reference values for the checks below, built apart from the datapath
  logic [7:0] ref_diff;
  logic ref_nb;
  logic ref_c;
  logic [7:0] ref_swap;
  logic [2:0] flags_now;
  assign ref_diff = file_q - acc_q;
  assign ref_c = (file_q >= acc_q);
  assign ref_nb = (file_q[3:0] >= acc_q[3:0]);
  assign ref_swap = {file_q[3:0], file_q[7:4]};
  assign flags_now = {carry_q, nib_borrow_bit_q, zero_q};

  sequence sleep_issued;
    fire && is_sleep && !wake_s;
  endsequence

  sequence sleep_effects;
    ##1 (lapse_clear_o && lapse_prescale_clear_o && osc_halt_o
      && timeout_flag_o && !powerdown_flag_o && (acc_q == 8'h00));
  endsequence

  chk_sleep_entry: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sleep_issued |-> sleep_effects)
    else $error("low-power entry effects missing");

  chk_sub_value: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (fire && is_sub) |=> (result_q == $past(ref_diff)) && (zero_q == (result_q == 8'h00)))
    else $error("subtract result or zero flag wrong");

  chk_sub_borrow: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (fire && is_sub) |=> (carry_q == $past(ref_c)) && (nib_borrow_bit_q == $past(ref_nb)))
    else $error("subtract carry or nibble borrow wrong");

  chk_sub_dest: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (fire && is_sub) |=> (file_we_o == res_dest_q)
      && (res_dest_q ? (file_wdata_o == result_q) : (acc_q == result_q)))
    else $error("subtract destination wrong");

  chk_swap_nibbles: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (fire && is_swap) |=> (result_q == $past(ref_swap)) && (flags_now == $past(flags_now)))
    else $error("swap result wrong or flags moved");

  chk_swap_dest: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (fire && is_swap && dec.dest) |=> file_we_o && (file_addr_o == $past(dec.faddr))
      ##1 (!file_we_o || !ce_i || $past(fire)))
    else $error("swap write-back wrong");

  chk_bus_answer: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (ce_i && req && state_q == BUS_IDLE) |=> !avs_waitrequest_o)
    else $error("bus answer late");

endmodule

// ### test/tb_top.sv
// self-checking bench for the sleep/subtract/swap execution unit with a behavioural model
`timescale 1ns/1ps
module tb_top
  import exec_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic wake_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [DATA_W-1:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [DATA_W-1:0] avs_readdata_o;
  logic avs_waitrequest_o, file_we_o, lapse_clear_o, lapse_prescale_clear_o;
  logic osc_halt_o, timeout_flag_o, powerdown_flag_o;
  logic [4:0] file_addr_o;
  logic [7:0] file_wdata_o;
  int err_count = 0;
  int checks = 0;

  sleep_subtract_swap_exec u_sleep_subtract_swap_exec (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .wake_i(wake_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
    .lapse_clear_o(lapse_clear_o), .lapse_prescale_clear_o(lapse_prescale_clear_o),
    .osc_halt_o(osc_halt_o), .timeout_flag_o(timeout_flag_o),
    .powerdown_flag_o(powerdown_flag_o)
  );

  always #4 core_clk_i = ~core_clk_i;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // the slave promises exactly one wait cycle, so the answer lands on the second edge
    check("bus_latency", n, 32'h2);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, a, wd, dummy);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] mask,
                        input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(name, v & mask, exp);
  endtask

  initial
  begin
    #200000;
    err_count++;
    results();
  end

  initial
  begin
    int ia, ifl, ires, i, n;
    logic [7:0] a, f, res;
    logic [4:0] fa;
    logic d, sw, m_to, m_pd;
    logic [2:0] fl, efl;
    void'($urandom(7671));
    repeat (5) @(posedge core_clk_i);
    check("rst_timeout", timeout_flag_o, 1'b1);
    check("rst_powerdown", powerdown_flag_o, 1'b1);
    check("rst_wait", avs_waitrequest_o, 1'b1);
    resetn_i <= 1'b1;
    m_to = 1'b1;
    m_pd = 1'b1;
    rd_chk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    $display("test reset done");
    for (i = 0; i < 48; i++)
    begin
      a = 8'($urandom);
      f = 8'($urandom);
      fa = 5'($urandom);
      d = 1'($urandom);
      fl = 3'($urandom);
      sw = i[0];
      if (i == 0)
        a = f;
      if (i == 2)
      begin
        f = 8'h00;
        a = 8'h01;
      end
      if (i == 4)
      begin
        f = 8'h10;
        a = 8'h01;
      end
      ia = a;
      ifl = f;
      if (sw)
      begin
        res = {f[3:0], f[7:4]};
        efl = fl;
      end
      else
      begin
        ires = (ifl - ia) & 255;
        res = ires[7:0];
        efl = {res == 8'h00, ifl[3:0] >= ia[3:0], ifl >= ia};
      end
      wr(REG_ACC_OFS, {24'h0, a});
      wr(REG_FILE_OFS, {24'h0, f});
      wr(REG_STATUS_OFS, {29'h0, fl});
      wr(REG_INSTR_OFS, {20'h0, sw ? OPC6_SWAP : OPC6_SUB, d, fa});
      #1;
      check("file_we", file_we_o, d);
      if (d)
      begin
        check("file_addr", file_addr_o, fa);
        check("file_wdata", file_wdata_o, res);
      end
      @(posedge core_clk_i);
      #1;
      check("file_we_end", file_we_o, 1'b0);
      rd_chk("acc", REG_ACC_OFS, 32'hff, d ? a : res);
      rd_chk("file", REG_FILE_OFS, 32'hff, d ? res : f);
      rd_chk("status", REG_STATUS_OFS, 32'h1f, {m_to, m_pd, efl});
      rd_chk("result", REG_RESULT_OFS, 32'h3fff, {d, fa, res});
    end
    $display("test subtract and swap done");
    wr(REG_ACC_OFS, 32'h5a);
    wr(REG_INSTR_OFS, {20'h0, OPC_SLEEP});
    m_to = 1'b1;
    m_pd = 1'b0;
    #1;
    check("lapse_clear", lapse_clear_o, 1'b1);
    check("prescale_clear", lapse_prescale_clear_o, 1'b1);
    check("osc_halt", osc_halt_o, 1'b1);
    check("timeout", timeout_flag_o, m_to);
    check("powerdown", powerdown_flag_o, m_pd);
    @(posedge core_clk_i);
    #1;
    check("lapse_clear_end", lapse_clear_o, 1'b0);
    check("prescale_end", lapse_prescale_clear_o, 1'b0);
    rd_chk("sleep_acc", REG_ACC_OFS, 32'hff, 32'h0);
    rd_chk("sleep_status", REG_STATUS_OFS, 32'h18, {m_to, m_pd, 3'b000});
    rd_chk("halt_state", REG_STATE_OFS, 32'h1, 32'h1);
    // an instruction while halted must not run
    wr(REG_INSTR_OFS, {20'h0, OPC6_SWAP, DEST_ACC, 5'h01});
    rd_chk("halted_instr", REG_INSTR_OFS, 32'hfff, {20'h0, OPC_SLEEP});
    rd_chk("halted_acc", REG_ACC_OFS, 32'hff, 32'h0);
    @(posedge core_clk_i);
    wake_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (osc_halt_o !== 1'b0 && n < 20);
    wake_i <= 1'b0;
    check("wake", osc_halt_o, 1'b0);
    check("wake_powerdown", powerdown_flag_o, m_pd);
    $display("test sleep done");
    results();
  end
endmodule
